// ### shared/wdg_pkg.sv
// Package with register map, reset values and timing constants of the watchdog
package wdg_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] PERIOD_INDEX = 8'ha7;
    localparam logic [ADDR_W-1:0] PERIOD_ADDR = {2'h0, PERIOD_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] SERVICE_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 12'h00c;
    localparam logic [7:0] SERVICE_KEY = 8'h5a;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic CONTROL_RESET = 1'b0;
    localparam int unsigned CLKS_PER_MACHINE = 12;
    localparam int unsigned TIMEOUT_EXP_BASE = 14;
    localparam int unsigned COUNT_W = 22;
    localparam int unsigned RESET_PULSE_CYCLES = 1;
    typedef enum logic [1:0] {
        WDG_RUN = 2'b00,
        WDG_POWER_DOWN = 2'b01,
        WDG_WAKE_WAIT = 2'b10
    } wdg_mode_type;
endpackage

// ### core/wdg_watchdog.sv
// Watchdog timer with time-out select, idle and power-down behaviour, APB slave
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog #(
    parameter int unsigned EXP_BASE = wdg_pkg::TIMEOUT_EXP_BASE,
    parameter int unsigned MACHINE_CLKS = wdg_pkg::CLKS_PER_MACHINE
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [wdg_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_idle,
    input wire logic i_power_down_req,
    input wire logic i_ext_int_enable,
    input wire logic i_ext_int_n,
    output logic o_power_down,
    output logic o_system_reset
);
    import wdg_pkg::*;

    // Wake-up pin synchroniser
    logic int_meta, next_int_meta;
    logic int_sync, next_int_sync;
    // Register bus
    logic access, rd_setup, wr, mapped;
    logic [31:0] rdata, next_rdata;
    // Period and control registers
    logic [2:0] timeout_select, next_timeout_select;
    logic enable, next_enable;
    logic service;
    // Power mode
    wdg_mode_type mode, next_mode;
    logic wake_armed, next_wake_armed;
    logic enter_pd;
    // Counter
    logic [3:0] prescale, next_prescale;
    logic [COUNT_W-1:0] count, next_count;
    logic sys_reset, next_sys_reset;
    logic counting, mc_tick, expire, fire;
    logic [COUNT_W-1:0] limit;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == PERIOD_ADDR) || (a == CONTROL_ADDR) || (a == SERVICE_ADDR) ||
                   (a == STATUS_ADDR) || (a == COUNT_ADDR);
    endfunction

    // Bus decode; read data is loaded at the setup edge so it stands in the access phase
    assign access = i_psel && i_penable;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign wr = access && i_pwrite;
    assign mapped = addr_hit(i_paddr);
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;
    assign o_prdata = rdata;
    assign o_power_down = (mode == WDG_POWER_DOWN);
    assign o_system_reset = sys_reset;

    // Pin passes two flip-flops before any logic reads it
    always_comb begin
        next_int_meta = i_ext_int_n;
        next_int_sync = int_meta;
    end

    always_ff @(posedge i_clk) begin
        int_meta <= next_int_meta;
        int_sync <= next_int_sync;
    end

    // Period and control registers
    always_comb begin
        next_timeout_select = timeout_select;
        next_enable = enable;
        if (wr && (i_paddr == PERIOD_ADDR)) begin
            next_timeout_select = i_pwdata[2:0];
        end
        if (wr && (i_paddr == CONTROL_ADDR)) begin
            next_enable = i_pwdata[0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            timeout_select <= SELECT_RESET;
            enable <= CONTROL_RESET;
        end else begin
            timeout_select <= next_timeout_select;
            enable <= next_enable;
        end
    end

    // Read data
    always_comb begin
        next_rdata = rdata;
        if (rd_setup) begin
            case (i_paddr)
                PERIOD_ADDR: next_rdata = {29'h0, timeout_select};
                CONTROL_ADDR: next_rdata = {31'h0, enable};
                STATUS_ADDR: next_rdata = {29'h0, sys_reset, mode};
                COUNT_ADDR: next_rdata = {10'h0, count};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Counter runs only in run mode, idle included; frozen in power-down and wake wait
    assign counting = enable && (mode == WDG_RUN);
    assign mc_tick = counting && (prescale == 4'(MACHINE_CLKS - 1));
    // Time-out is 2^(base+select) machine cycles; limit is that count minus one
    assign limit = COUNT_W'((23'h1 << (EXP_BASE + 32'(timeout_select))) - 23'h1);
    assign expire = mc_tick && (count >= limit);
    assign service = wr && (i_paddr == SERVICE_ADDR) && (i_pwdata[7:0] == SERVICE_KEY);
    // A service in the time-out cycle wins, so no pulse
    assign fire = expire && !service;

    always_comb begin
        next_prescale = prescale;
        next_count = count;
        next_sys_reset = 1'b0;
        if (service) begin
            next_prescale = 4'h0;
            next_count = '0;
        end else if (fire) begin
            next_sys_reset = 1'b1;
            next_prescale = 4'h0;
            next_count = '0;
        end else if (counting) begin
            if (mc_tick) begin
                next_prescale = 4'h0;
                next_count = count + COUNT_W'(1);
            end else begin
                next_prescale = prescale + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prescale <= 4'h0;
            count <= '0;
            sys_reset <= 1'b0;
        end else begin
            prescale <= next_prescale;
            count <= next_count;
            sys_reset <= next_sys_reset;
        end
    end

    // Power-down is not entered in a cycle that fires the reset pulse
    assign enter_pd = (mode == WDG_RUN) && i_power_down_req && !i_idle && !fire;

    // Interrupt wake is armed only if enabled when power-down was entered
    always_comb begin
        next_mode = mode;
        next_wake_armed = wake_armed;
        case (mode)
            WDG_RUN: begin
                if (enter_pd) begin
                    next_mode = WDG_POWER_DOWN;
                    next_wake_armed = i_ext_int_enable;
                end
            end
            WDG_POWER_DOWN: begin
                if (wake_armed && !int_sync) begin
                    next_mode = WDG_WAKE_WAIT;
                end
            end
            WDG_WAKE_WAIT: begin
                // Counter stays halted until the pin is high again
                if (int_sync) begin
                    next_mode = WDG_RUN;
                    next_wake_armed = 1'b0;
                end
            end
            default: begin
                next_mode = WDG_RUN;
                next_wake_armed = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            // Hardware reset also leaves power-down
            mode <= WDG_RUN;
            wake_armed <= 1'b0;
        end else begin
            mode <= next_mode;
            wake_armed <= next_wake_armed;
        end
    end
endmodule
`default_nettype wire

// ### bench/wdg_watchdog_props.sv
// Port checker for the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog_props import wdg_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic i_idle,
    input wire logic i_ext_int_enable,
    input wire logic o_pslverr,
    input wire logic o_power_down,
    input wire logic o_system_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire logic acc = i_psel && i_penable;
    logic en_at_entry;
    always_ff @(posedge i_clk) begin
        if (!o_power_down) begin
            en_at_entry <= i_ext_int_enable;
        end
    end
    sequence s_calm;
        !o_system_reset [*2];
    endsequence
    a_pd_quiet: assert property (o_power_down |-> !o_system_reset) else $error("pulse in power-down");
    a_pd_hold: assert property (o_power_down && !en_at_entry |=> o_power_down) else $error("left sleep");
    a_wake_src: assert property ($fell(o_power_down) |-> $past(en_at_entry) || $past(i_reset))
        else $error("bad wake");
    a_wake_halt: assert property ($fell(o_power_down) |-> s_calm) else $error("pulse after wake");
    a_idle_stay: assert property (i_idle && !o_power_down |=> !o_power_down) else $error("sleep in idle");
    a_pulse_gap: assert property (o_system_reset |=> !o_system_reset [*3]) else $error("pulses too close");
    a_map_ok: assert property (acc && i_paddr == PERIOD_ADDR |-> !o_pslverr) else $error("period refused");
    a_map_bad: assert property (acc && i_paddr > COUNT_ADDR && i_paddr != PERIOD_ADDR |-> o_pslverr)
        else $error("unmapped taken");
endmodule
bind wdg_watchdog wdg_watchdog_props u_props (.*);
`default_nettype wire

// ### bench/test_watchdog_timeout_power_modes.sv
// Self-checking testbench of the watchdog
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timeout_power_modes;
    import wdg_pkg::*;
    localparam int E = 2;
    localparam int M = 2;
    logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_idle = 0, i_pd = 0, i_en = 0;
    logic i_int_n = 1;
    logic [ADDR_W-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, rd, v;
    logic o_pready, o_pslverr, o_power_down, o_system_reset, err;
    int num_errors = 0, cmp_count = 0, n;
    always #50 i_clk = ~i_clk;
    wdg_watchdog #(.EXP_BASE(E), .MACHINE_CLKS(M)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_idle(i_idle), .i_power_down_req(i_pd),
        .i_ext_int_enable(i_en), .i_ext_int_n(i_int_n), .o_power_down(o_power_down), .o_system_reset(o_system_reset));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        err = o_pslverr;
        rd = o_prdata;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge i_clk);
            c++;
        end while (o_system_reset !== 1'b1 && c < 3000);
    endtask
    task automatic t_regs;
        apb(0, PERIOD_ADDR, 0);
        chk("select reset", rd, 0);
        apb(1, PERIOD_ADDR, 32'hff);
        apb(0, PERIOD_ADDR, 0);
        chk("period", rd, 7);
        apb(0, 12'h100, 0);
        chk("unmapped err", {31'h0, err}, 1);
        chk("unmapped rd", rd, 0);
    endtask
    task automatic t_sel;
        apb(1, CONTROL_ADDR, 1);
        for (int s = 0; s < 8; s++) begin
            apb(1, PERIOD_ADDR, 32'(s));
            gap(n);
            gap(n);
            chk("timeout gap", 32'(n), 32'((2 ** (E + s)) * M));
        end
    endtask
    task automatic t_idle;
        apb(1, PERIOD_ADDR, 0);
        i_idle <= 1;
        i_pd <= 1;
        gap(n);
        chk("idle counts", {30'h0, n < 3000, o_power_down}, 2);
    endtask
    task automatic t_pd;
        apb(1, PERIOD_ADDR, 3);
        apb(1, SERVICE_ADDR, {24'h0, SERVICE_KEY});
        i_idle <= 0;
        apb(0, COUNT_ADDR, 0);
        v = rd;
        repeat (100) @(posedge i_clk);
        apb(0, COUNT_ADDR, 0);
        chk("frozen count", rd, v);
        chk("in power-down", o_power_down, 1);
        i_int_n <= 0;
        i_en <= 1;
        repeat (10) @(posedge i_clk);
        chk("not armed", o_power_down, 1);
        i_int_n <= 1;
        i_reset <= 1;
        @(posedge i_clk);
        i_reset <= 0;
        i_pd <= 0;
        apb(0, PERIOD_ADDR, 0);
        chk("reset exit pd", o_power_down, 0);
        chk("reset exit select", rd, 0);
        apb(1, CONTROL_ADDR, 1);
        apb(1, PERIOD_ADDR, 3);
        apb(1, SERVICE_ADDR, {24'h0, SERVICE_KEY});
        i_pd <= 1;
        @(posedge i_clk);
        i_pd <= 0;
        apb(0, COUNT_ADDR, 0);
        v = rd;
        i_int_n <= 0;
        repeat (100) @(posedge i_clk);
        apb(0, COUNT_ADDR, 0);
        chk("held low count", rd, v);
        chk("woken", o_power_down, 0);
        i_int_n <= 1;
        apb(1, SERVICE_ADDR, {24'h0, SERVICE_KEY});
        gap(n);
        chk("restart", n < 3000, 1);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 0;
        t_regs;
        t_sel;
        t_idle;
        t_pd;
        tally_and_finish;
    end
endmodule
`default_nettype wire
